// [hw/dcu_map.vh]
// register map, field positions, reset values and timing counts
`ifndef DCU_MAP_VH
`define DCU_MAP_VH

// timing
`define DCU_CLK_MHZ 200
`define DCU_RST_PULSE_NS 10
`define DCU_RST_PULSE_CYC (((`DCU_RST_PULSE_NS * `DCU_CLK_MHZ) + 999) / 1000)
`define DCU_RST_BUSY_NS 100
`define DCU_RST_BUSY_CYC ((`DCU_RST_BUSY_NS * `DCU_CLK_MHZ) / 1000)

// single-byte register addresses
`define DCU_A_IFACE_CFG 7'h00
`define DCU_A_RANGE_BASE 7'h04
`define DCU_A_FILTER_BASE 7'h0a
`define DCU_A_PIN_LOAD_MASK 7'h10
`define DCU_A_SOFT_LOAD 7'h11
`define DCU_A_CHAN_CFG 7'h14
`define DCU_A_ALARM_CFG 7'h15
`define DCU_A_BCAST_SEL 7'h3b

// two-byte registers, lsb address given, msb at lsb plus one
`define DCU_A_IN_LSB_BASE 7'h20
`define DCU_A_OUT_LSB_BASE 7'h30
`define DCU_A_BCAST_IN_LSB 7'h3c
`define DCU_A_BCAST_OUT_LSB 7'h3e
`define DCU_A_WIDE_FIRST 7'h20

// field positions
`define DCU_B_SRST_HI 7
`define DCU_B_SRST_LO 0
`define DCU_B_SINK_EN 7
`define DCU_B_OPEN_DRAIN 0
`define DCU_F_TRIM_HI 7
`define DCU_F_TRIM_LO 2
`define DCU_F_RANGE_HI 1
`define DCU_F_RANGE_LO 0

// reset values
`define DCU_R_IFACE_CFG 8'h00
`define DCU_R_CHAN_CFG 8'hbf
`define DCU_R_RANGE 8'h00
`define DCU_R_FILTER 4'h0
`define DCU_R_ALARM_CFG 8'h00

// range codes
`define DCU_C0_SOURCE 2'h0
`define DCU_C0_SINK 2'h1
`define DCU_C0_BIPOLAR 2'h2
`define DCU_C1_LOW_HEADROOM 2'h1
`define DCU_C1_LOW_NOISE 2'h2
`define DCU_C1_WIDE 2'h3
`define DCU_CX_LOWER 2'h0
`define DCU_CX_UPPER 2'h1

`endif

// [hw/dcu_sync.v]
// two flip-flop synchroniser for a bundle of level inputs
`timescale 1ns/10ps
`default_nettype none
module dcu_sync #(
  parameter WIDTH = 1,
  parameter [WIDTH-1:0] INIT = {WIDTH{1'b0}}
) (
  input wire ref_clk,
  input wire rst_b,
  input wire [WIDTH-1:0] async_in,
  output reg [WIDTH-1:0] sync_out
);
  reg [WIDTH-1:0] meta_q;

  always @(posedge ref_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      meta_q <= INIT;
      sync_out <= INIT;
    end
    else
    begin
      meta_q <= async_in;
      sync_out <= meta_q;
    end
  end
endmodule
`default_nettype wire

// [hw/dcu_rx.v]
// serial write receiver: instruction byte then streaming data bytes
`timescale 1ns/10ps
`default_nettype none
module dcu_rx (
  input wire ref_clk,
  input wire rst_b,
  input wire sclk_s,
  input wire cs_n_s,
  input wire sdi_s,
  output reg byte_valid_q,
  output reg [6:0] byte_addr_q,
  output reg [7:0] byte_data_q,
  output reg frame_end_q
);
  reg sclk_prev_q;
  reg cs_prev_q;
  reg [2:0] bit_cnt_q;
  reg [7:0] shift_q;
  reg in_data_q;
  reg is_read_q;
  reg [6:0] addr_q;
  wire rise;
  wire [7:0] nxt;

  assign rise = sclk_s & ~sclk_prev_q & ~cs_n_s;
  assign nxt = {shift_q[6:0], sdi_s};

  always @(posedge ref_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      sclk_prev_q <= 1'b0;
      cs_prev_q <= 1'b1;
      bit_cnt_q <= 3'h0;
      shift_q <= 8'h00;
      in_data_q <= 1'b0;
      is_read_q <= 1'b0;
      addr_q <= 7'h00;
      byte_valid_q <= 1'b0;
      byte_addr_q <= 7'h00;
      byte_data_q <= 8'h00;
      frame_end_q <= 1'b0;
    end
    else
    begin
      sclk_prev_q <= sclk_s;
      cs_prev_q <= cs_n_s;
      frame_end_q <= cs_n_s & ~cs_prev_q;
      byte_valid_q <= 1'b0;
      if (cs_n_s)
      begin
        // partial bytes are dropped
        bit_cnt_q <= 3'h0;
        in_data_q <= 1'b0;
      end
      else if (rise)
      begin
        shift_q <= nxt;
        bit_cnt_q <= bit_cnt_q + 3'h1;
        if (bit_cnt_q == 3'h7)
        begin
          if (!in_data_q)
          begin
            in_data_q <= 1'b1;
            is_read_q <= nxt[7];
            addr_q <= nxt[6:0];
          end
          else
          begin
            byte_valid_q <= ~is_read_q;
            byte_addr_q <= addr_q;
            byte_data_q <= nxt;
            addr_q <= addr_q - 7'h01;
          end
        end
      end
    end
  end
endmodule
`default_nettype wire

// [hw/dcu_ctrl.v]
// six-channel converter update control: codes, loads, ranges, alarm pin
//
// Contract
// - low reset pin resets every register
// - both soft reset bits reset all but iface
// - soft reset bits clear themselves
// - input and output code registers kept apart
// - load pin fall copies unmasked inputs
// - load pin low: lsb write updates output
// - mask bit excludes channel from pin loads
// - soft load copies selected, then self-clears
// - input broadcast writes selected input registers
// - output broadcast writes selected output registers
// - channel 0 sink enable, on at power-up
// - outputs start shut down, per-channel off bits
// - channel 0 range codes 0,1,2
// - channel 1 range codes 1,2,3
// - channels 2-5 lower or upper range
// - filter code selects output resistor
// - trim scales fullscale, sourcing modes only
// - trim applies at next output code write
// - alarm push-pull, open-drain when enabled
// - two-byte writes commit only whole, msb first
`timescale 1ns/10ps
`default_nettype none
`include "dcu_map.vh"
module dcu_ctrl #(
  parameter NCH = 6,
  parameter CW = 14
) (
  input wire ref_clk,
  input wire rst_b,
  input wire sclk,
  input wire cs_n,
  input wire sdi,
  input wire load_strobe_n,
  input wire alarm_req,
  output wire [NCH*CW-1:0] out_code,
  output wire [NCH-1:0] chan_output_off,
  output wire chan0_sink_enable,
  output wire [NCH*2-1:0] chan_range_code,
  output wire [NCH-1:0] chan_sourcing,
  output wire [NCH*6-1:0] fullscale_trim_code,
  output wire [NCH*4-1:0] chan_filter_setting,
  output reg alarm_out_n,
  output reg alarm_oe_n
);
  ////////////////////////////////////////////////////////////////////////
  // pin sampling and byte receiver
  wire sclk_s;
  wire cs_n_s;
  wire sdi_s;
  wire load_s;
  wire bv;
  wire [6:0] ba;
  wire [7:0] bd;
  wire frame_end;

  dcu_sync #(
    .WIDTH(4),
    .INIT(4'b1100)
  ) u_sync (
    .ref_clk(ref_clk),
    .rst_b(rst_b),
    .async_in({load_strobe_n, cs_n, sclk, sdi}),
    .sync_out({load_s, cs_n_s, sclk_s, sdi_s})
  );

  dcu_rx u_rx (
    .ref_clk(ref_clk),
    .rst_b(rst_b),
    .sclk_s(sclk_s),
    .cs_n_s(cs_n_s),
    .sdi_s(sdi_s),
    .byte_valid_q(bv),
    .byte_addr_q(ba),
    .byte_data_q(bd),
    .frame_end_q(frame_end)
  );

  ////////////////////////////////////////////////////////////////////////
  // two-byte write assembly
  reg [7:0] pend_q;
  reg [6:0] pend_addr_q;
  reg pend_v_q;
  wire is_wide;
  wire commit;
  wire [CW-1:0] word;

  assign is_wide = (ba >= `DCU_A_WIDE_FIRST);
  assign commit = bv & is_wide & ~ba[0] & pend_v_q & (pend_addr_q == ba + 7'h01);
  assign word = {pend_q, bd[7:2]};

  always @(posedge ref_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      pend_q <= 8'h00;
      pend_addr_q <= 7'h00;
      pend_v_q <= 1'b0;
    end
    else if (frame_end)
    begin
      pend_v_q <= 1'b0;
    end
    else if (bv)
    begin
      pend_q <= bd;
      pend_addr_q <= ba;
      pend_v_q <= is_wide & ba[0];
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // single-byte control registers
  reg [7:0] iface_q;
  reg sreset_q;
  reg [NCH-1:0] pin_mask_q;
  reg [NCH-1:0] soft_load_q;
  reg [NCH-1:0] sel_q;
  reg [7:0] chan_cfg_q;
  reg [7:0] alarm_cfg_q;
  reg load_prev_q;
  wire load_fall;
  wire bcast_in;
  wire bcast_out;

  assign load_fall = load_prev_q & ~load_s;
  assign bcast_in = commit & (ba == `DCU_A_BCAST_IN_LSB);
  assign bcast_out = commit & (ba == `DCU_A_BCAST_OUT_LSB);

  always @(posedge ref_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      iface_q <= `DCU_R_IFACE_CFG;
      sreset_q <= 1'b0;
    end
    else if (bv && ba == `DCU_A_IFACE_CFG)
    begin
      iface_q <= bd & 8'h7e;
      sreset_q <= bd[`DCU_B_SRST_HI] & bd[`DCU_B_SRST_LO];
    end
    else
    begin
      sreset_q <= 1'b0;
    end
  end

  always @(posedge ref_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      pin_mask_q <= {NCH{1'b0}};
      soft_load_q <= {NCH{1'b0}};
      sel_q <= {NCH{1'b0}};
      chan_cfg_q <= `DCU_R_CHAN_CFG;
      alarm_cfg_q <= `DCU_R_ALARM_CFG;
      load_prev_q <= 1'b1;
    end
    else if (sreset_q)
    begin
      pin_mask_q <= {NCH{1'b0}};
      soft_load_q <= {NCH{1'b0}};
      sel_q <= {NCH{1'b0}};
      chan_cfg_q <= `DCU_R_CHAN_CFG;
      alarm_cfg_q <= `DCU_R_ALARM_CFG;
      load_prev_q <= load_s;
    end
    else
    begin
      load_prev_q <= load_s;
      if (bv && ba == `DCU_A_SOFT_LOAD)
        soft_load_q <= bd[NCH-1:0];
      else
        soft_load_q <= {NCH{1'b0}};
      if (bv && ba == `DCU_A_PIN_LOAD_MASK)
        pin_mask_q <= bd[NCH-1:0];
      if (bv && ba == `DCU_A_BCAST_SEL)
        sel_q <= bd[NCH-1:0];
      if (bv && ba == `DCU_A_CHAN_CFG)
        chan_cfg_q <= bd;
      if (bv && ba == `DCU_A_ALARM_CFG)
        alarm_cfg_q <= bd;
    end
  end

  assign chan_output_off = chan_cfg_q[NCH-1:0];
  assign chan0_sink_enable = chan_cfg_q[`DCU_B_SINK_EN];

  ////////////////////////////////////////////////////////////////////////
  // per-channel code, range, filter and trim
  genvar n;
  generate
    for (n = 0; n < NCH; n = n + 1)
    begin : g_ch
      reg [CW-1:0] in_q;
      reg [CW-1:0] out_q;
      reg [7:0] range_q;
      reg [3:0] filter_q;
      reg [5:0] trim_q;
      reg src_q;
      reg [CW-1:0] in_d;
      wire in_wr;
      wire out_wr;
      wire copy;
      wire src_d;

      assign in_wr = commit & (ba == `DCU_A_IN_LSB_BASE + 2 * n);
      assign out_wr = commit & (ba == `DCU_A_OUT_LSB_BASE + 2 * n);
      assign copy = ((load_fall | (in_wr & ~load_s)) & ~pin_mask_q[n])
        | soft_load_q[n];
      if (n == 0)
      begin : g_src0
        assign src_d = (range_q[1:0] == `DCU_C0_SOURCE);
      end
      else
      begin : g_srcx
        assign src_d = 1'b1;
      end

      always @*
      begin
        in_d = in_q;
        if (bcast_in && sel_q[n])
          in_d = word;
        else if (in_wr)
          in_d = word;
      end

      always @(posedge ref_clk or negedge rst_b)
      begin
        if (!rst_b)
        begin
          in_q <= {CW{1'b0}};
          out_q <= {CW{1'b0}};
          range_q <= `DCU_R_RANGE;
          filter_q <= `DCU_R_FILTER;
          trim_q <= 6'h00;
          src_q <= 1'b1;
        end
        else if (sreset_q)
        begin
          in_q <= {CW{1'b0}};
          out_q <= {CW{1'b0}};
          range_q <= `DCU_R_RANGE;
          filter_q <= `DCU_R_FILTER;
          trim_q <= 6'h00;
          src_q <= 1'b1;
        end
        else
        begin
          in_q <= in_d;
          if (bv && ba == `DCU_A_RANGE_BASE + n)
            range_q <= bd;
          if (bv && ba == `DCU_A_FILTER_BASE + n)
            filter_q <= bd[3:0];
          src_q <= src_d;
          if (out_wr || (bcast_out && sel_q[n]) || copy)
          begin
            if (out_wr || (bcast_out && sel_q[n]))
              out_q <= word;
            else
              out_q <= in_d;
            trim_q <= src_d ? range_q[`DCU_F_TRIM_HI:`DCU_F_TRIM_LO] : 6'h00;
          end
        end
      end

      assign out_code[n*CW +: CW] = out_q;
      assign chan_range_code[n*2 +: 2] = range_q[`DCU_F_RANGE_HI:`DCU_F_RANGE_LO];
      assign chan_sourcing[n] = src_q;
      assign fullscale_trim_code[n*6 +: 6] = trim_q;
      assign chan_filter_setting[n*4 +: 4] = filter_q;
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////
  // alarm pin drive
  always @(posedge ref_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      alarm_out_n <= 1'b1;
      alarm_oe_n <= 1'b0;
    end
    else if (alarm_cfg_q[`DCU_B_OPEN_DRAIN])
    begin
      alarm_out_n <= 1'b0;
      alarm_oe_n <= ~alarm_req;
    end
    else
    begin
      alarm_out_n <= ~alarm_req;
      alarm_oe_n <= 1'b0;
    end
  end
endmodule
`default_nettype wire

// [bench/dcu_checker.sv]
// port assertions for the update control block
`timescale 1ns/10ps
`default_nettype none
module dcu_checker (
  input wire logic ref_clk,
  input wire logic rst_b,
  input wire logic sclk,
  input wire logic cs_n,
  input wire logic sdi,
  input wire logic load_strobe_n,
  input wire logic alarm_req,
  input wire logic [83:0] out_code,
  input wire logic [5:0] chan_output_off,
  input wire logic chan0_sink_enable,
  input wire logic [11:0] chan_range_code,
  input wire logic [5:0] chan_sourcing,
  input wire logic [35:0] fullscale_trim_code,
  input wire logic [23:0] chan_filter_setting,
  input wire logic alarm_out_n,
  input wire logic alarm_oe_n
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rst_b);
  // link and load pin both idle
  sequence quiet;
    (cs_n && load_strobe_n) [*8];
  endsequence
  AST_RST_CODE: assert property (disable iff (1'b0)
    !rst_b && $past(!rst_b) |-> out_code == '0 && fullscale_trim_code == '0)
    else $error("code not reset");
  AST_RST_CFG: assert property (disable iff (1'b0)
    !rst_b && $past(!rst_b) |-> chan_output_off == '1 && chan0_sink_enable
    && chan_range_code == '0)
    else $error("config not reset");
  AST_RST_ALM: assert property (disable iff (1'b0)
    !rst_b && $past(!rst_b) |-> alarm_out_n && !alarm_oe_n && chan_filter_setting == '0)
    else $error("alarm not reset");
  AST_REL: assert property ($rose(rst_b) |-> out_code == '0 && chan_output_off == '1)
    else $error("bad state after reset");
  AST_ALM_ON: assert property (alarm_req |=> !alarm_out_n && !alarm_oe_n)
    else $error("alarm not driven low");
  AST_ALM_OFF: assert property (!alarm_req |=> alarm_out_n != alarm_oe_n)
    else $error("idle alarm wrong");
  AST_HOLD: assert property (quiet |=> $stable(out_code) && $stable(chan_output_off))
    else $error("output moved while idle");
  AST_SRC: assert property (chan_sourcing[5:1] == '1)
    else $error("source-only channel not sourcing");
endmodule
`default_nettype wire

// [bench/dcu_host.sv]
// host model: serial write frames, clock idles low
`timescale 1ns/10ps
`default_nettype none
module dcu_host (
  output var logic sclk,
  output var logic cs_n,
  output var logic sdi
);
  initial
  begin
    sclk = 0;
    cs_n = 1;
    sdi = 0;
  end
  // write frame, bytes taken from top of d
  task send(input logic [6:0] a, input int n, input logic [31:0] d);
    logic [39:0] f;
    f = {1'b0, a, d};
    cs_n = 0;
    for (int k = 0; k < 8 + 8 * n; k++)
    begin
      sdi = f[39 - k];
      #24 sclk = 1;
      #24 sclk = 0;
    end
    #24 cs_n = 1;
    sdi = ~sdi;
    #100;
  endtask
endmodule
`default_nettype wire

// [bench/dcu_ctrl_test.sv]
// bench for the update control block
`timescale 1ns/10ps
`default_nettype none
module dcu_ctrl_test;
  logic ref_clk = 0;
  logic rst_b = 0;
  logic load_strobe_n = 1;
  logic alarm_req = 0;
  wire sclk, cs_n, sdi, sink, ao, aoe;
  wire [83:0] oc;
  wire [5:0] off, src;
  wire [11:0] rng;
  wire [35:0] trim;
  wire [23:0] flt;
  int n_mismatch = 0;
  int compares = 0;
  int i;
  logic [3:0] fc [8] = '{4'h0, 4'h5, 4'h6, 4'h7, 4'h8, 4'h9, 4'h3, 4'hf};
  always #2.5 ref_clk = ~ref_clk;
  dcu_host i_host (.sclk(sclk), .cs_n(cs_n), .sdi(sdi));
  dcu_ctrl i_dut (.ref_clk(ref_clk), .rst_b(rst_b), .sclk(sclk), .cs_n(cs_n), .sdi(sdi),
    .load_strobe_n(load_strobe_n), .alarm_req(alarm_req), .out_code(oc),
    .chan_output_off(off), .chan0_sink_enable(sink), .chan_range_code(rng),
    .chan_sourcing(src), .fullscale_trim_code(trim), .chan_filter_setting(flt),
    .alarm_out_n(ao), .alarm_oe_n(aoe));
  task chk(input logic [127:0] g, input logic [127:0] e);
    compares++;
    if (g !== e)
    begin
      n_mismatch++;
      $display("ERROR %0t got %h exp %h", $time, g, e);
    end
  endtask
  task cyc(input int k);
    repeat (k) @(negedge ref_clk);
  endtask
  task wr(input logic [6:0] a, input int n, input logic [31:0] d);
    i_host.send(a, n, d);
  endtask
  task pin(input logic v);
    cyc(1);
    load_strobe_n = v;
    cyc(10);
  endtask
  task al(input logic v, input logic [1:0] e);
    cyc(1);
    alarm_req = v;
    cyc(3);
    chk({ao, aoe}, e);
  endtask
  task report_and_stop;
    $display("compares %0d mismatches %0d", compares, n_mismatch);
    if (n_mismatch == 0 && compares > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  initial
  begin
    #100000;
    n_mismatch++;
    $display("ERROR %0t run limit reached", $time);
    report_and_stop;
  end
  initial
  begin
    cyc(12);
    rst_b = 1;
    cyc(1);
    chk(oc, 84'h0);
    chk({off, sink, rng, flt, trim}, {6'h3f, 1'b1, 72'h0});
    chk({ao, aoe}, 2'b10);
    cyc(20);
    wr(7'h21, 2, 32'hfffc_0000);
    chk(oc[13:0], 14'h0);
    pin(0);
    chk(oc[13:0], 14'h3fff);
    pin(1);
    wr(7'h10, 1, 32'h0100_0000);
    wr(7'h23, 4, 32'h1234_0a04);
    pin(0);
    chk(oc[27:0], {14'h048d, 14'h3fff});
    wr(7'h23, 2, 32'h5678_0000);
    chk(oc[27:14], 14'h159e);
    pin(1);
    $display("end load pin");
    wr(7'h11, 1, 32'h0100_0000);
    chk(oc[13:0], 14'h0281);
    wr(7'h3b, 1, 32'h3000_0000);
    wr(7'h3f, 4, 32'h1122_3344);
    chk(oc[83:42], {14'h0448, 14'h0448, 14'h0});
    wr(7'h11, 1, 32'h1000_0000);
    chk(oc[83:56], {14'h0448, 14'h0cd1});
    wr(7'h31, 1, 32'h2200_0000);
    chk(oc[13:0], 14'h0281);
    $display("end copies");
    wr(7'h14, 1, 32'hbf00_0000);
    wr(7'h04, 1, 32'h1400_0000);
    chk(trim[5:0], 6'h0);
    wr(7'h31, 2, 32'h0);
    chk(trim[5:0], 6'h05);
    for (i = 1; i < 3; i++)
    begin
      wr(7'h04, 1, {6'h0, i[1:0], 24'h0});
      chk({rng[1:0], src[0]}, {i[1:0], 1'b0});
    end
    wr(7'h31, 2, 32'h0);
    chk(trim[5:0], 6'h0);
    for (i = 1; i < 4; i++)
    begin
      wr(7'h05, 1, {6'h0, i[1:0], 24'h0});
      chk(rng[3:2], i[1:0]);
    end
    wr(7'h09, 4, 32'h0101_0101);
    chk({rng[11:4], src[5:1]}, {8'h55, 5'h1f});
    for (i = 0; i < 8; i++)
    begin
      wr(7'h0c, 1, {4'h0, fc[i], 24'h0});
      chk(flt[11:8], fc[i]);
    end
    wr(7'h14, 1, 32'h0200_0000);
    chk({off, sink}, {6'h02, 1'b0});
    $display("end modes");
    al(1, 2'b00);
    al(0, 2'b10);
    wr(7'h15, 1, 32'h0100_0000);
    al(1, 2'b00);
    al(0, 2'b01);
    wr(7'h00, 1, 32'h8100_0000);
    chk({oc, off, sink, rng}, {84'h0, 6'h3f, 1'b1, 12'h0});
    al(0, 2'b10);
    wr(7'h14, 1, 32'h0);
    chk(off, 6'h0);
    cyc(1);
    rst_b = 0;
    #1 chk(off, 6'h3f);
    cyc(2);
    rst_b = 1;
    cyc(20);
    chk({off, sink}, {6'h3f, 1'b1});
    $display("end resets");
    report_and_stop;
  end
endmodule
bind dcu_ctrl dcu_checker i_chk (.ref_clk(ref_clk), .rst_b(rst_b), .sclk(sclk), .cs_n(cs_n),
  .sdi(sdi), .load_strobe_n(load_strobe_n), .alarm_req(alarm_req), .out_code(out_code),
  .chan_output_off(chan_output_off), .chan0_sink_enable(chan0_sink_enable),
  .chan_range_code(chan_range_code), .chan_sourcing(chan_sourcing),
  .fullscale_trim_code(fullscale_trim_code), .chan_filter_setting(chan_filter_setting),
  .alarm_out_n(alarm_out_n), .alarm_oe_n(alarm_oe_n));
`default_nettype wire
